// [ppm_params.svh]
// Offsets, field positions, reset values and codes of the power-management capability
`ifndef PPM_PARAMS_SVH
`define PPM_PARAMS_SVH
`define PPM_CAP_OFFSET      8'hc0
`define PPM_CTL_OFFSET      8'hc4
`define PPM_CAPABILITY_IDENTIFIER_VALUE     8'h01
`define PPM_CAPABILITY_IDENTIFIER_LSB       0
`define PPM_D3C_BIT         31
`define PPM_WSTAT_BIT       15
`define PPM_DATA_SCALE_FIELD_LSB       13
`define PPM_DATA_SELECT_FIELD_LSB        9
`define PPM_WEN_BIT         8
`define PPM_PWR_LSB         0
`define PPM_DATA_SELECT_FIELD_RESET      4'h0
`define PPM_PWR_RESET       2'h0
`define PPM_DATA_SCALE_FIELD_VALUE     2'h0
`define PPM_CAP_OTHER_BITS  32'h7e03_0000
`endif

// [ppm_pkg.sv]
// Types of the power-management capability block
package ppm_pkg;
  typedef enum logic [1:0] {
    PPM_D0    = 2'h0,
    PPM_D1    = 2'h1,
    PPM_D2    = 2'h2,
    PPM_D3HOT = 2'h3
  } ppm_pstate_t;
endpackage

// [ppm_regs.sv]
// Power-management capability registers on the configuration port
`timescale 1ns/100ps
`include "ppm_params.svh"
module ppm_regs
  import ppm_pkg::*;
#(
  parameter logic [3:0] SUPPORTED_STATES = 4'hf
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        por,
  input  wire logic        eeprom_d3c,
  input  wire logic        aux_detect,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic [31:0]      cfg_rdata,
  input  wire logic        wake_event,
  output logic             pme_n,
  output logic [1:0]       power_state
);
  // Field positions must sit inside their byte lanes and keep clear of each other
  localparam int unsigned PWR_LSB   = `PPM_PWR_LSB;
  localparam int unsigned WEN_BIT   = `PPM_WEN_BIT;
  localparam int unsigned DATA_SELECT_FIELD_LSB  = `PPM_DATA_SELECT_FIELD_LSB;
  localparam int unsigned DATA_SCALE_FIELD_LSB = `PPM_DATA_SCALE_FIELD_LSB;
  localparam int unsigned WSTAT_BIT = `PPM_WSTAT_BIT;
  localparam int unsigned D3C_BIT   = `PPM_D3C_BIT;

  if (SUPPORTED_STATES[0] == 1'b0) begin
    $error("ppm_regs: power state D0 must be supported");
  end
  if (PWR_LSB + 2 > 8) begin
    $error("ppm_regs: power state field must sit in byte lane 0");
  end
  if (WEN_BIT < 8 || WEN_BIT > 15) begin
    $error("ppm_regs: enable bit must sit in byte lane 1");
  end
  if (DATA_SELECT_FIELD_LSB < 8 || DATA_SELECT_FIELD_LSB + 4 > 16) begin
    $error("ppm_regs: data select field must sit in byte lane 1");
  end
  if (DATA_SCALE_FIELD_LSB + 2 > 16) begin
    $error("ppm_regs: data scale field must sit in the low half");
  end
  if (WSTAT_BIT < 8 || WSTAT_BIT > 15) begin
    $error("ppm_regs: status bit must sit in byte lane 1");
  end
  if (D3C_BIT > 31) begin
    $error("ppm_regs: D3cold flag must sit inside the word");
  end
  if (WEN_BIT >= DATA_SELECT_FIELD_LSB || DATA_SELECT_FIELD_LSB + 4 > DATA_SCALE_FIELD_LSB || DATA_SCALE_FIELD_LSB + 2 > WSTAT_BIT) begin
    $error("ppm_regs: control fields overlap");
  end
  if (`PPM_CAP_OFFSET == `PPM_CTL_OFFSET || (`PPM_CTL_OFFSET % 4) != 0) begin
    $error("ppm_regs: register offsets must differ and be word aligned");
  end
  if (`PPM_CAPABILITY_IDENTIFIER_LSB != 0) begin
    $error("ppm_regs: identifier must sit in the first byte");
  end

  // Strap, sticky wake controls and the non-sticky data select and power state fields
  logic        d3c_q;
  logic        d3c_d;
  logic        wstat_q;
  logic        wen_q;
  logic [3:0]  data_select_field_q;
  ppm_pstate_t pwr_q;
  // Reset combinations, decodes of one configuration access and the packed read words
  logic        any_reset;
  logic        sticky_reset;
  logic        wr_ctl;
  logic        rd_cap;
  logic        rd_ctl;
  logic        lane_state;
  logic        lane_wake;
  logic        status_clr;
  logic        pwr_take;
  logic [31:0] cap_word;
  logic [31:0] ctl_word;
  logic [31:0] rdata_d;
  logic [1:0]  new_pwr;

  // One decoder for both strobes keeps reads and writes on the same map
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] base);
    return addr == base;
  endfunction

  // Only four codes exist, so every code indexes the mask
  function automatic logic state_ok(input logic [1:0] code);
    return SUPPORTED_STATES[code];
  endfunction

  // Packing lives in functions so the read mux and the field map cannot drift apart
  function automatic logic [31:0] pack_cap(input logic d3c);
    logic [31:0] w;
    w = `PPM_CAP_OTHER_BITS;
    w[`PPM_CAPABILITY_IDENTIFIER_LSB +: 8] = `PPM_CAPABILITY_IDENTIFIER_VALUE;
    w[D3C_BIT] = d3c;
    return w;
  endfunction

  function automatic logic [31:0] pack_ctl(input logic wstat, input logic wen,
                                            input logic [3:0] data_select_field, input logic [1:0] pwr);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[WSTAT_BIT] = wstat;
    w[DATA_SCALE_FIELD_LSB +: 2] = `PPM_DATA_SCALE_FIELD_VALUE;
    w[DATA_SELECT_FIELD_LSB +: 4] = data_select_field;
    w[WEN_BIT] = wen;
    w[PWR_LSB +: 2] = pwr;
    return w;
  endfunction

  assign d3c_d        = eeprom_d3c && aux_detect;
  assign any_reset    = por || rst;
  // Uses the incoming strap, so a one-edge reset already clears unsupported bits
  assign sticky_reset = por || (rst && !d3c_d);
  assign wr_ctl       = cfg_wr && addr_hit(cfg_addr, `PPM_CTL_OFFSET);
  assign rd_cap       = cfg_rd && addr_hit(cfg_addr, `PPM_CAP_OFFSET);
  assign rd_ctl       = cfg_rd && addr_hit(cfg_addr, `PPM_CTL_OFFSET);
  // Byte lane 0 carries the power state, lane 1 the wake controls
  assign lane_state   = wr_ctl && cfg_be[0];
  assign lane_wake    = wr_ctl && cfg_be[1];
  assign new_pwr      = cfg_wdata[PWR_LSB +: 2];
  assign status_clr   = lane_wake && cfg_wdata[WSTAT_BIT];
  assign pwr_take     = lane_state && state_ok(new_pwr);

  // Strap is taken on the clock while reset is held, never through the async path
  always_ff @(posedge mclk) begin
    if (any_reset) begin
      d3c_q <= d3c_d;
    end
  end

  // Sticky bits: only power-up reset clears them when D3cold wake is supported
  always_ff @(posedge mclk) begin
    if (sticky_reset) begin
      wstat_q <= 1'b0;
    end else if (wake_event) begin
      wstat_q <= 1'b1;
    end else if (status_clr) begin
      wstat_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sticky_reset) begin
      wen_q <= 1'b0;
    end else if (lane_wake) begin
      wen_q <= cfg_wdata[WEN_BIT];
    end
  end

  // Stored only so software reads back what it wrote; nothing decodes it
  always_ff @(posedge mclk) begin
    if (any_reset) begin
      data_select_field_q <= `PPM_DATA_SELECT_FIELD_RESET;
    end else if (lane_wake) begin
      data_select_field_q <= cfg_wdata[DATA_SELECT_FIELD_LSB +: 4];
    end
  end

  // A refused code leaves the field alone while the bus write still completes
  always_ff @(posedge mclk) begin
    if (any_reset) begin
      pwr_q <= ppm_pstate_t'(`PPM_PWR_RESET);
    end else if (pwr_take) begin
      pwr_q <= ppm_pstate_t'(new_pwr);
    end
  end

  // Active low pin, registered so it never glitches on the enable write
  always_ff @(posedge mclk) begin
    if (por || rst) begin
      pme_n <= 1'b1;
    end else begin
      pme_n <= !(wstat_q && wen_q);
    end
  end

  // Output copy lags the field by one cycle so the pin comes from a flop
  always_ff @(posedge mclk) begin
    if (any_reset) begin
      power_state <= `PPM_PWR_RESET;
    end else begin
      power_state <= pwr_q;
    end
  end

  // Unmapped and idle cycles read zero
  always_comb begin
    cap_word = pack_cap(d3c_q);
    ctl_word = pack_ctl(wstat_q, wen_q, data_select_field_q, pwr_q);
    rdata_d  = 32'h0000_0000;
    if (rd_cap) begin
      rdata_d = cap_word;
    end else if (rd_ctl) begin
      rdata_d = ctl_word;
    end
  end

  // Read data stands for one cycle only, then falls back to zero
  always_ff @(posedge mclk) begin
    if (any_reset) begin
      cfg_rdata <= 32'h0000_0000;
    end else begin
      cfg_rdata <= rdata_d;
    end
  end
endmodule

// [ppm_host.sv]
// Host bridge model issuing configuration accesses
`timescale 1ns/100ps
module ppm_host (
  input  logic        mclk,
  output logic        cfg_wr,
  output logic        cfg_rd,
  output logic [7:0]  cfg_addr,
  output logic [3:0]  cfg_be,
  output logic [31:0] cfg_wdata
);
  initial {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = '0;
  // Released data is flipped so a stale word never looks valid
  task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(negedge mclk) {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = {w, !w, a, b, d};
    @(negedge mclk) {cfg_wr, cfg_rd, cfg_wdata} = {2'b00, ~d};
  endtask
endmodule

// [ppm_regs_sva.sv]
// Port checker of the power-management registers
`timescale 1ns/100ps
module ppm_regs_sva #(parameter logic [3:0] SUPPORTED_STATES = 4'hf) (
  input logic        mclk,
  input logic        rst,
  input logic        por,
  input logic        cfg_wr,
  input logic        cfg_rd,
  input logic [7:0]  cfg_addr,
  input logic [3:0]  cfg_be,
  input logic [31:0] cfg_wdata,
  input logic [31:0] cfg_rdata,
  input logic        wake_event,
  input logic        pme_n,
  input logic [1:0]  power_state
);
  wire r4 = cfg_rd && cfg_addr == 8'hc4;
  wire w4 = cfg_wr && cfg_addr == 8'hc4 && cfg_be[0];
  wire ok = SUPPORTED_STATES[cfg_wdata[1:0]];
  default clocking @(posedge mclk); endclocking
  default disable iff (rst || por);
  a_capability_identifier_ok: assert property (cfg_rd && cfg_addr == 8'hc0 |=> cfg_rdata[7:0] == 1) else $error("f");
  a_wake_sets: assert property (wake_event ##1 r4 |=> cfg_rdata[15]) else $error("f");
  a_clear_pme: assert property (cfg_wr && cfg_addr == 8'hc4 && cfg_be[1] && cfg_wdata[15]
    && !wake_event |-> ##2 pme_n) else $error("f");
  // A write one cycle back may already have moved the enable
  a_pme_gate: assert property (!pme_n && r4 && !$past(cfg_wr) |=> cfg_rdata[15] && cfg_rdata[8])
    else $error("f");
  a_scale_zero: assert property (cfg_rd |=> cfg_rdata[14:13] == 0) else $error("f");
  a_resv_zero: assert property (r4 |=> cfg_rdata[31:16] == 0 && cfg_rdata[7:2] == 0) else $error("f");
  a_pwr_take: assert property (w4 && ok |-> ##2 power_state == $past(cfg_wdata[1:0], 2)) else $error("f");
  a_pwr_keep: assert property (w4 && !ok |-> ##2 $stable(power_state)) else $error("f");
  c_pme: cover property (!pme_n);
  c_d3: cover property (power_state == 3);
  c_clr: cover property ($rose(pme_n));
endmodule
bind ppm_regs ppm_regs_sva #(.SUPPORTED_STATES(SUPPORTED_STATES)) i_sva (.*);

// [pci_power_mgmt_capability_tb.sv]
// Bench of the power-management registers
`timescale 1ns/100ps
module pci_power_mgmt_capability_tb;
  logic mclk = 0, rst = 1, por = 1, aux = 1, wake = 0, pme_n, wr, rd;
  logic [1:0] pst;
  logic [3:0] be;
  logic [7:0] ad;
  logic [31:0] wd, q, r = 32'h313b_1a00;
  int err_count = 0, n_checks = 0;
  localparam logic [3:0] ST = 4'hb;
  logic [31:0] m;
  always #5 mclk = ~mclk;
  ppm_host i_host (.mclk, .cfg_wr(wr), .cfg_rd(rd), .cfg_addr(ad), .cfg_be(be), .cfg_wdata(wd));
  ppm_regs #(.SUPPORTED_STATES(ST)) i_dut (.mclk, .rst, .por, .eeprom_d3c(1'b1), .aux_detect(aux),
    .cfg_wr(wr), .cfg_rd(rd), .cfg_addr(ad), .cfg_be(be), .cfg_wdata(wd), .cfg_rdata(q),
    .wake_event(wake), .pme_n, .power_state(pst));
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Expected control word after one write, from the field map and the supported mask
  function automatic logic [31:0] upd(input logic [31:0] m0, input logic [3:0] b,
                                      input logic [31:0] d);
    logic [31:0] v;
    v = m0;
    if (b[1]) begin
      v[12:8] = d[12:8];
      if (d[15]) v[15] = 1'b0;
    end
    if (b[0] && ST[d[1:0]]) v[1:0] = d[1:0];
    return v;
  endfunction
  task automatic ck(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  // Zero byte enables mean a read, checked against e
  task automatic acc(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d, e);
    i_host.acc(b != 0, a, b, d);
    if (b == 0) ck("cfg_rdata", e, q);
  endtask
  task automatic rset(input logic p);
    {rst, por} = {1'b1, p};
    repeat (8) @(negedge mclk);
    {rst, por} = 2'b00;
  endtask
  task automatic test_done;
    if (err_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(negedge mclk);
    err_count++;
    test_done;
  end
  initial begin
    rset(1);
    acc(8'hc0, 0, 0, 32'hfe03_0001);
    acc(8'hc4, 0, 0, 0);
    r = nx(r);
    acc(8'hc4, 3, r & 32'hffff_7efc | 32'h0000_0101, 0);
    acc(8'hc4, 0, 0, {19'h0, r[12:9], 9'h101});
    @(negedge mclk) wake = 1;
    @(negedge mclk) wake = 0;
    @(negedge mclk) ck("pme_n", 0, pme_n);
    rset(0);
    acc(8'hc4, 2, 32'h0000_0100, 0);
    acc(8'hc4, 0, 0, 32'h0000_8100);
    acc(8'hc4, 2, 32'h0000_0000, 0);
    acc(8'hc4, 0, 0, 32'h0000_8000);
    ck("pme_n", 1, pme_n);
    acc(8'hc4, 2, 32'h0000_8000, 0);
    acc(8'hc4, 0, 0, 0);
    ck("pme_n", 1, pme_n);
    for (int i = 0; i < 4; i++) begin
      acc(8'hc4, 1, i, 0);
      acc(8'hc4, 0, 0, i == 2 ? 1 : i);
      ck("power_state", i == 2 ? 1 : i, pst);
    end
    m = 32'h0000_0003;
    for (int k = 0; k < 24; k++) begin
      r = nx(r);
      acc(8'hc4, r[19:16] | 4'h4, r, 0);
      m = upd(m, r[19:16] | 4'h4, r);
      acc(8'hc4, 0, 0, m);
    end
    aux = 0;
    rset(0);
    acc(8'hc0, 0, 0, 32'h7e03_0001);
    acc(8'hc4, 2, 32'h0000_0100, 0);
    rset(0);
    acc(8'hc4, 0, 0, 0);
    test_done;
  end
endmodule
